// ### logic/acw_pkg.sv
package acw_pkg;

  // Bus geometry
  localparam int APB_ADDR_W = 8;
  localparam int APB_DATA_W = 32;

  // Register byte addresses
  localparam logic [7:0] OFS_CONV_CTRL = 8'h00;
  localparam logic [7:0] OFS_FMT_CLK = 8'h04;
  localparam logic [7:0] OFS_RES_LOW = 8'h08;
  localparam logic [7:0] OFS_RES_HIGH = 8'h0c;
  localparam logic [7:0] OFS_KEY_WAKE = 8'h10;

  // Converter control fields
  localparam int BIT_POWER_EN = 7;
  localparam int BIT_GO = 6;
  localparam int BIT_DONE = 5;
  localparam int BIT_IRQ_EN = 0;

  // Format and clock fields
  localparam int BIT_LEN_SEL = 7;
  localparam int BIT_JUSTIFY = 6;
  localparam int TS_LSB = 3;
  localparam int DIV_LSB = 0;

  // Key wake fields
  localparam int BIT_WAKE_EN = 7;
  localparam int BIT_WAKE_FLAG = 6;

  // Reset values and widths
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam int RES_W = 12;
  localparam int TICK_W = 5;
  localparam int RATIO_W = 6;

  // Conversion length per timing class, in converter clocks
  localparam logic [2:0] TS_FAST = 3'h0;
  localparam logic [2:0] TS_MID_A = 3'h1;
  localparam logic [2:0] TS_MID_B = 3'h2;
  localparam logic [4:0] TICKS_FAST = 5'h16;
  localparam logic [4:0] TICKS_MID = 5'h13;
  localparam logic [4:0] TICKS_SLOW = 5'h0f;

  // Sequencer states
  typedef enum logic {
    SEQ_IDLE = 1'b0,
    SEQ_RUN = 1'b1
  } acw_seq_state_type;

  // Converter clocks needed by one conversion
  function automatic logic [4:0] conv_ticks(input logic [2:0] ts);
    logic [4:0] n;
    n = TICKS_SLOW;
    if (ts == TS_FAST)
      n = TICKS_FAST;
    else if (ts == TS_MID_A || ts == TS_MID_B)
      n = TICKS_MID;
    return n;
  endfunction

  // System clocks per converter clock
  function automatic logic [5:0] div_ratio(input logic [2:0] sel);
    logic [5:0] r;
    r = 6'h02;
    case (sel)
      3'h0: r = 6'h02;
      3'h1: r = 6'h04;
      3'h2: r = 6'h06;
      3'h3: r = 6'h08;
      3'h4: r = 6'h0c;
      3'h5: r = 6'h10;
      3'h6: r = 6'h18;
      3'h7: r = 6'h20;
      default: r = 6'h02;
    endcase
    return r;
  endfunction

endpackage

// ### logic/acw_conv_seq.sv
`timescale 1ns/1ns
module acw_conv_seq
  import acw_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Control
  input wire logic start_in,
  input wire logic abort_in,
  input wire logic [2:0] div_sel_in,
  input wire logic [2:0] timing_sel_in,
  // Status
  output logic busy_out,
  output logic tick_out,
  output logic done_out
);

  acw_seq_state_type state_r;
  logic [RATIO_W-1:0] div_cnt_r;
  logic [RATIO_W-1:0] ratio_r;
  logic [TICK_W-1:0] tick_cnt_r;
  logic [TICK_W-1:0] need_r;
  logic tick_r;
  logic done_r;
  logic running;
  logic tick_now;
  logic last_tick;

  // Divider end and conversion end
  assign running = (state_r == SEQ_RUN);
  assign tick_now = running & (div_cnt_r == RATIO_W'(ratio_r - 6'h01)); // R7
  assign last_tick = tick_now & (tick_cnt_r == TICK_W'(need_r - 5'h01)); // R4 R5 R6
  assign busy_out = running;
  assign tick_out = tick_r;
  assign done_out = done_r;

  // Ratio and length are latched at start so a mid-run rewrite cannot tear a conversion
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      state_r <= SEQ_IDLE;
      div_cnt_r <= '0;
      tick_cnt_r <= '0;
      ratio_r <= '0;
      need_r <= '0;
      tick_r <= 1'b0;
      done_r <= 1'b0;
    end
    else
    begin
      tick_r <= tick_now;
      done_r <= last_tick & ~abort_in;
      unique case (state_r)
        SEQ_IDLE:
        begin
          if (start_in)
          begin
            state_r <= SEQ_RUN;
            div_cnt_r <= '0;
            tick_cnt_r <= '0;
            ratio_r <= div_ratio(div_sel_in); // R7
            need_r <= conv_ticks(timing_sel_in); // R4 R5 R6
          end
        end
        SEQ_RUN:
        begin
          if (abort_in || last_tick)
            state_r <= SEQ_IDLE; // R15
          div_cnt_r <= tick_now ? '0 : RATIO_W'(div_cnt_r + 6'h01);
          if (tick_now)
            tick_cnt_r <= TICK_W'(tick_cnt_r + 5'h01);
        end
      endcase
    end
  end

endmodule

// ### logic/acw_conv_ctrl.sv
`timescale 1ns/1ns
// Behaviour
// R1: Length bit selects 12 or upper 10 bits
// R2: Justify 0: top eight high, rest low
// R3: Justify 1: top bits high nibble, eight low
// R4: Timing class 000 takes 22 clocks
// R5: Timing class 001/010 takes 19 clocks
// R6: Timing class 011..111 takes 15 clocks
// R7: Divider select gives ratios 2..32
// R8: Software enables and configures before starting
// R9: Go starts; completion clears go, sets done
// R10: Software clears done, then reads result
// R11: Repeat start, clear, read without reconfiguring
// R12: Software keeps converter off while wake enabled
// R13: Wake detect sets flag, shares converter interrupt
// R14: Disabled wake module never sets flag
// R15: Clearing go mid-conversion aborts it
// R16: Done set blocks a new start
// R17: Power-down forces converter power off
// R18: Wake during power-down wakes chip
// R19: Result bytes update with done, then hold
module acw_conv_ctrl
  import acw_pkg::*;
(
  // Clock and reset
  input wire logic SYS_CLK_IN,
  input wire logic RST_IN,
  // APB slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [APB_ADDR_W-1:0] PADDR_IN,
  input wire logic [APB_DATA_W-1:0] PWDATA_IN,
  output logic [APB_DATA_W-1:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // Analog converter side
  input wire logic [RES_W-1:0] CONV_DATA_IN,
  output logic CONV_POWER_EN_OUT,
  output logic CONV_BUSY_OUT,
  output logic CONV_CLK_TICK_OUT,
  // Key wake and power state
  input wire logic KEY_WAKE_DET_IN,
  input wire logic POWER_DOWN_IN,
  output logic KEY_WAKE_EN_OUT,
  output logic WAKE_REQ_OUT,
  // Shared converter interrupt request
  output logic CONV_IRQ_OUT
);

  logic power_en_r;
  logic power_en_nxt;
  logic done_r;
  logic done_nxt;
  logic irq_en_r;
  logic [7:0] fmt_clk_r;
  logic [7:0] res_low_r;
  logic [7:0] res_high_r;
  logic wake_en_r;
  logic wake_flag_r;
  logic wake_flag_nxt;
  logic wake_req_r;
  logic [APB_DATA_W-1:0] prdata_r;

  // Bus decode
  logic setup_ph;
  logic wr_en;
  logic hit_ctrl;
  logic hit_fmt;
  logic hit_low;
  logic hit_high;
  logic hit_wake;
  logic addr_hit;
  logic wr_ctrl;
  logic wr_fmt;
  logic wr_wake;
  assign setup_ph = PSEL_IN & ~PENABLE_IN;
  assign wr_en = PSEL_IN & PENABLE_IN & PWRITE_IN;
  assign hit_ctrl = (PADDR_IN == OFS_CONV_CTRL);
  assign hit_fmt = (PADDR_IN == OFS_FMT_CLK);
  assign hit_low = (PADDR_IN == OFS_RES_LOW);
  assign hit_high = (PADDR_IN == OFS_RES_HIGH);
  assign hit_wake = (PADDR_IN == OFS_KEY_WAKE);
  assign addr_hit = hit_ctrl | hit_fmt | hit_low | hit_high | hit_wake;
  assign wr_ctrl = wr_en & hit_ctrl;
  assign wr_fmt = wr_en & hit_fmt;
  assign wr_wake = wr_en & hit_wake;

  // Zero-wait slave; unmapped addresses answer with an error
  assign PREADY_OUT = 1'b1;
  assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~addr_hit;
  assign PRDATA_OUT = prdata_r;

  // Format and clock fields
  logic len_sel;
  logic justify;
  logic [2:0] timing_sel;
  logic [2:0] div_sel;
  assign len_sel = fmt_clk_r[BIT_LEN_SEL];
  assign justify = fmt_clk_r[BIT_JUSTIFY];
  assign timing_sel = fmt_clk_r[TS_LSB+2:TS_LSB];
  assign div_sel = fmt_clk_r[DIV_LSB+2:DIV_LSB];

  // Sequencer handshake
  logic seq_busy;
  logic seq_tick;
  logic seq_done;
  logic start_req;
  logic abort_req;
  assign start_req = wr_ctrl & PWDATA_IN[BIT_GO] & ~done_r & ~seq_busy & ~seq_done; // R9 R16 R11
  // Power loss also aborts, since a converter without supply gives garbage
  assign abort_req = seq_busy & ((wr_ctrl & ~PWDATA_IN[BIT_GO]) | ~power_en_r); // R15

  acw_conv_seq u_seq (
    .clk_in(SYS_CLK_IN),
    .rst_in(RST_IN),
    .start_in(start_req),
    .abort_in(abort_req),
    .div_sel_in(div_sel),
    .timing_sel_in(timing_sel),
    .busy_out(seq_busy),
    .tick_out(seq_tick),
    .done_out(seq_done)
  );

  // Result formatting from the raw sample
  logic [7:0] fmt_high;
  logic [7:0] fmt_low;
  logic [7:0] left_low;
  logic [7:0] right_high;
  logic [7:0] right_low;
  assign left_low = len_sel ? {6'h00, CONV_DATA_IN[3:2]} : {4'h0, CONV_DATA_IN[3:0]}; // R1 R2
  assign right_high = len_sel ? {6'h00, CONV_DATA_IN[11:10]} : {4'h0, CONV_DATA_IN[11:8]}; // R1 R3
  assign right_low = len_sel ? CONV_DATA_IN[9:2] : CONV_DATA_IN[7:0]; // R1 R3
  assign fmt_high = justify ? right_high : CONV_DATA_IN[11:4]; // R2 R3
  assign fmt_low = justify ? right_low : left_low; // R2 R3

  // Flag next values; a hardware set wins over a same-cycle software clear
  assign done_nxt = seq_done | (done_r & ~(wr_ctrl & ~PWDATA_IN[BIT_DONE])); // R9
  logic wake_set;
  assign wake_set = wake_en_r & KEY_WAKE_DET_IN; // R13 R14
  assign wake_flag_nxt = wake_set | (wake_flag_r & ~(wr_wake & ~PWDATA_IN[BIT_WAKE_FLAG]));
  assign power_en_nxt = POWER_DOWN_IN ? 1'b0 : (wr_ctrl ? PWDATA_IN[BIT_POWER_EN] : power_en_r); // R17

  // Read data mux, captured in the setup phase
  logic [7:0] ctrl_rd;
  logic [7:0] wake_rd;
  logic [7:0] rd_byte;
  assign ctrl_rd = {power_en_r, seq_busy, done_r, 4'h0, irq_en_r};
  assign wake_rd = {wake_en_r, wake_flag_r, 6'h00};
  assign rd_byte = hit_ctrl ? ctrl_rd :
                   hit_fmt ? fmt_clk_r :
                   hit_low ? res_low_r :
                   hit_high ? res_high_r :
                   hit_wake ? wake_rd : 8'h00;

  // Control and status registers
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (RST_IN)
    begin
      power_en_r <= 1'b0;
      done_r <= 1'b0;
      irq_en_r <= 1'b0;
      fmt_clk_r <= RST_BYTE;
      wake_en_r <= 1'b0;
      wake_flag_r <= 1'b0;
      wake_req_r <= 1'b0;
    end
    else
    begin
      power_en_r <= power_en_nxt;
      done_r <= done_nxt;
      wake_flag_r <= wake_flag_nxt;
      wake_req_r <= wake_set & POWER_DOWN_IN; // R18
      if (wr_ctrl)
        irq_en_r <= PWDATA_IN[BIT_IRQ_EN];
      if (wr_fmt)
        fmt_clk_r <= PWDATA_IN[7:0];
      if (wr_wake)
        wake_en_r <= PWDATA_IN[BIT_WAKE_EN];
    end
  end

  // Result bytes change only at completion
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (RST_IN)
    begin
      res_low_r <= RST_BYTE;
      res_high_r <= RST_BYTE;
    end
    else if (seq_done)
    begin
      res_low_r <= fmt_low; // R19
      res_high_r <= fmt_high; // R19
    end
  end

  // Read data register
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (RST_IN)
      prdata_r <= '0;
    else if (setup_ph)
      prdata_r <= {24'h000000, rd_byte};
  end

  // Outputs
  assign CONV_POWER_EN_OUT = power_en_r;
  assign CONV_BUSY_OUT = seq_busy;
  assign CONV_CLK_TICK_OUT = seq_tick;
  assign KEY_WAKE_EN_OUT = wake_en_r;
  assign WAKE_REQ_OUT = wake_req_r;
  assign CONV_IRQ_OUT = irq_en_r & (done_r | wake_flag_r); // R9 R13

  // Helper: ticks and gaps seen during one conversion
  logic [TICK_W-1:0] chk_ticks_r;
  logic [TICK_W-1:0] chk_need_r;
  logic [RATIO_W-1:0] chk_ratio_r;
  logic [RATIO_W-1:0] chk_gap_r;
  logic chk_seen_r;
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (RST_IN || start_req)
    begin
      chk_ticks_r <= '0;
      chk_gap_r <= '0;
      chk_seen_r <= 1'b0;
      chk_need_r <= conv_ticks(timing_sel);
      chk_ratio_r <= div_ratio(div_sel);
    end
    else if (seq_tick)
    begin
      chk_ticks_r <= TICK_W'(chk_ticks_r + 5'h01);
      chk_gap_r <= '0;
      chk_seen_r <= 1'b1;
    end
    else
      chk_gap_r <= RATIO_W'(chk_gap_r + 6'h01);
  end

  default clocking cb @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (RST_IN);

  sequence s_start;
    start_req ##1 seq_busy;
  endsequence

  sequence s_finish;
    seq_done ##1 done_r;
  endsequence

  a_start_runs: assert property (start_req |-> s_start) // R9
    else $error("start request did not begin a conversion");

  a_done_blocks_go: assert property (done_r && !seq_busy |=> !seq_busy) // R16
    else $error("conversion began while done flag set");

  a_finish_sets_done: assert property (seq_done |-> (!seq_busy and s_finish)) // R9
    else $error("completion did not clear go and set done");

  a_result_load: assert property (seq_done |=> res_high_r == $past(fmt_high) && res_low_r == $past(fmt_low)) // R19
    else $error("result bytes not loaded at completion");

  a_result_hold: assert property (!seq_done |=> $stable(res_high_r) && $stable(res_low_r)) // R19
    else $error("result bytes changed without completion");

  a_left_justify: assert property (seq_done && !justify && !len_sel |=> res_high_r == $past(CONV_DATA_IN[11:4]) && res_low_r[7:4] == 4'h0) // R1 R2
    else $error("left justified layout wrong");

  a_right_ten_bit: assert property (seq_done && justify && len_sel |=> res_high_r == {6'h00, $past(CONV_DATA_IN[11:10])} && res_low_r == $past(CONV_DATA_IN[9:2])) // R1 R3
    else $error("right justified ten bit layout wrong");

  a_conv_length: assert property (seq_done |-> seq_tick && chk_ticks_r == TICK_W'(chk_need_r - 5'h01)) // R4 R5 R6
    else $error("conversion length differs from timing class");

  a_tick_spacing: assert property (seq_tick && chk_seen_r |-> chk_gap_r == RATIO_W'(chk_ratio_r - 6'h01)) // R7
    else $error("converter clock spacing differs from divider");

  a_abort_stops: assert property (abort_req |=> !seq_busy ##1 !done_r || $past(done_r)) // R15
    else $error("abort did not stop the conversion");

  a_wake_gated: assert property (!wake_en_r && !wake_flag_r |=> !wake_flag_r) // R14
    else $error("wake flag set while wake module disabled");

  a_wake_sets: assert property (wake_en_r && KEY_WAKE_DET_IN |=> wake_flag_r ##0 (!irq_en_r || CONV_IRQ_OUT)) // R13
    else $error("wake detect did not set flag and interrupt");

  a_wake_pd: assert property (wake_en_r && KEY_WAKE_DET_IN && POWER_DOWN_IN |=> WAKE_REQ_OUT) // R18
    else $error("wake during power-down gave no wake request");

  a_pd_power_off: assert property (POWER_DOWN_IN |=> !CONV_POWER_EN_OUT) // R17
    else $error("converter power stayed on in power-down");

endmodule

// ### tb/acw_conv_ctrl_tb_top.sv
`timescale 1ns/1ns
module acw_conv_ctrl_tb_top
  import acw_pkg::*;
;
  // Bench signals
  logic clk, rst, psel, pen, pwr, kdet, pdn;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, pwr_en, busy, tick, ken, wreq, irq;
  logic [11:0] cdata;
  int miscompares, n_tests;

  acw_conv_ctrl u_acw_conv_ctrl (
    .SYS_CLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .CONV_DATA_IN(cdata), .CONV_POWER_EN_OUT(pwr_en),
    .CONV_BUSY_OUT(busy), .CONV_CLK_TICK_OUT(tick), .KEY_WAKE_DET_IN(kdet),
    .POWER_DOWN_IN(pdn), .KEY_WAKE_EN_OUT(ken), .WAKE_REQ_OUT(wreq), .CONV_IRQ_OUT(irq)
  );

  // 10 MHz system clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic print_verdict;
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer; holds the request until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    for (k = 0; k < 50; k++)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    if (k == 50)
    begin
      miscompares++;
      print_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, {24'h0, d}, r, e);
  endtask

  task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(what, {24'h0, exp}, r);
    chk("slave error", 32'h0, {31'h0, e});
  endtask

  // Reset values, unmapped address, read-only result bytes
  task automatic t_reset;
    logic [31:0] r;
    logic e;
    rchk("ctrl", OFS_CONV_CTRL, RST_BYTE);
    rchk("format", OFS_FMT_CLK, RST_BYTE);
    rchk("wake", OFS_KEY_WAKE, RST_BYTE);
    wr(OFS_RES_LOW, 8'hff);
    rchk("low", OFS_RES_LOW, RST_BYTE);
    rchk("high", OFS_RES_HIGH, RST_BYTE);
    apb(1'b0, 8'h20, 32'h0, r, e);
    chk("unmapped data", 32'h0, r);
    chk("unmapped error", 32'h1, {31'h0, e});
  endtask

  // One conversion per divider code; length, justify and timing vary with it
  task automatic t_conv(input logic [2:0] i);
    int ratio[8] = '{2, 4, 6, 8, 12, 16, 24, 32};
    logic [11:0] d;
    logic [9:0] v;
    logic [7:0] eh, el;
    int n, nt, en;
    d = 12'hb6d + {9'h0, i} * 12'h111;
    v = d[11:2];
    en = (i == 3'h0) ? 22 : (i < 3'h3) ? 19 : 15;
    eh = i[1] ? (i[0] ? {6'h0, v[9:8]} : {4'h0, d[11:8]}) : d[11:4];
    el = i[1] ? (i[0] ? v[7:0] : d[7:0]) : (i[0] ? {6'h0, d[3:2]} : {4'h0, d[3:0]});
    cdata <= d;
    wr(OFS_FMT_CLK, {i[0], i[1], i, i});
    wr(OFS_CONV_CTRL, 8'h81);
    wr(OFS_CONV_CTRL, 8'hc1);
    nt = 0;
    for (n = 1; n <= 1200; n++)
    begin
      @(posedge clk);
      #1;
      if (tick === 1'b1)
        nt++;
      if (irq === 1'b1)
        break;
    end
    // Flag lands one edge after the last converter clock; first look is one edge after the write
    chk("conversion cycles", en * ratio[i] + 1, n);
    if (n > 1200)
    begin
      miscompares++;
      print_verdict();
    end
    chk("converter ticks", en, nt);
    @(posedge clk);
    cdata <= ~d;
    rchk("ctrl done", OFS_CONV_CTRL, 8'ha1);
    rchk("high", OFS_RES_HIGH, eh);
    rchk("low", OFS_RES_LOW, el);
    wr(OFS_CONV_CTRL, 8'h81);
    rchk("ctrl cleared", OFS_CONV_CTRL, 8'h81);
  endtask

  // Blocked start, restart without reconfiguring, abort, power-down
  task automatic t_block;
    cdata <= 12'h3c5;
    wr(OFS_FMT_CLK, 8'h00);
    wr(OFS_CONV_CTRL, 8'hc1);
    repeat (50) @(posedge clk);
    wr(OFS_CONV_CTRL, 8'hc1);
    repeat (3) @(posedge clk);
    #1;
    chk("busy blocked", 32'h0, {31'h0, busy});
    wr(OFS_CONV_CTRL, 8'h81);
    cdata <= 12'h5a6;
    wr(OFS_CONV_CTRL, 8'hc1);
    repeat (5) @(posedge clk);
    #1;
    chk("busy restart", 32'h1, {31'h0, busy});
    wr(OFS_CONV_CTRL, 8'h81);
    repeat (60) @(posedge clk);
    rchk("ctrl aborted", OFS_CONV_CTRL, 8'h81);
    rchk("high kept", OFS_RES_HIGH, 8'h3c);
    wr(OFS_CONV_CTRL, 8'hc1);
    repeat (3) @(posedge clk);
    pdn <= 1'b1;
    @(posedge clk);
    pdn <= 1'b0;
    #1;
    chk("power forced off", 32'h0, {31'h0, pwr_en});
    repeat (60) @(posedge clk);
    rchk("ctrl after powerdown", OFS_CONV_CTRL, 8'h01);
    rchk("low kept", OFS_RES_LOW, 8'h05);
  endtask

  // Wake detector: disabled, enabled in power-down, flag clear
  task automatic t_wake;
    kdet <= 1'b1;
    pdn <= 1'b1;
    repeat (4) @(posedge clk);
    kdet <= 1'b0;
    pdn <= 1'b0;
    #1;
    chk("wake request off", 32'h0, {31'h0, wreq});
    rchk("wake disabled", OFS_KEY_WAKE, 8'h00);
    wr(OFS_KEY_WAKE, 8'h80);
    #1;
    chk("wake enable", 32'h1, {31'h0, ken});
    wr(OFS_CONV_CTRL, 8'h01);
    @(posedge clk);
    kdet <= 1'b1;
    pdn <= 1'b1;
    @(posedge clk);
    kdet <= 1'b0;
    pdn <= 1'b0;
    #1;
    chk("wake request", 32'h1, {31'h0, wreq});
    chk("shared irq", 32'h1, {31'h0, irq});
    @(posedge clk);
    #1;
    chk("wake request pulse", 32'h0, {31'h0, wreq});
    rchk("wake flag", OFS_KEY_WAKE, 8'hc0);
    wr(OFS_KEY_WAKE, 8'h80);
    rchk("wake flag cleared", OFS_KEY_WAKE, 8'h80);
    chk("irq cleared", 32'h0, {31'h0, irq});
  endtask

  // Main sequence
  initial
  begin
    miscompares = 0;
    n_tests = 0;
    rst = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cdata = 12'h000;
    kdet = 1'b0;
    pdn = 1'b0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    for (int i = 0; i < 8; i++)
      t_conv(i[2:0]);
    t_block();
    t_wake();
    print_verdict();
  end
endmodule
